// >>> design/data_space_address_decoder.sv
`timescale 1ns/1ns
`include "data_space_cfg.svh"
module data_space_address_decoder #(
    parameter int LOW_RAM_BYTES = `LOW_RAM_DEFAULT_BYTES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // core data access
    input wire data_space_pkg::data_req_t req,
    output data_space_pkg::byte_t rd_data,
    // core operand resolution
    input wire data_space_pkg::operand_req_t operand,
    output data_space_pkg::byte_t operand_addr,
    output logic operand_is_imm,
    output data_space_pkg::byte_t operand_bit_mask,
    // accumulator and program counter
    input wire logic acc_load,
    input wire data_space_pkg::byte_t acc_value,
    input wire logic pc_load,
    input wire logic [`PC_WIDTH-1:0] pc_value,
    input wire logic counter_high_load,
    input wire logic [`PC_WIDTH-`PC_HIGH_LSB-1:0] counter_high_value,
    output data_space_pkg::byte_t acc_q,
    output logic [`PC_WIDTH-1:0] program_counter_q,
    output logic [`PC_WIDTH-`PC_HIGH_LSB-1:0] counter_high_part_q,
    // pins
    input wire data_space_pkg::byte_t port_l_pins,
    input wire data_space_pkg::byte_t port_g_pins,
    input wire data_space_pkg::byte_t input_only_pins,
    // register contents toward the peripherals
    output data_space_pkg::periph_regs_t regs_q
);

    if (LOW_RAM_BYTES < 1 || LOW_RAM_BYTES > `LOW_SPACE_BYTES) begin : g_bad_ram
        $error("data_space_address_decoder: LOW_RAM_BYTES out of range");
    end

    localparam int STORE_DEPTH = LOW_RAM_BYTES + `REG_PAGE_BYTES;
    localparam int STORE_AW = $clog2(STORE_DEPTH);
    localparam logic [8:0] LOW_RAM_LIMIT = 9'(LOW_RAM_BYTES);
    localparam logic [STORE_AW-1:0] REG_PAGE_BASE = STORE_AW'(LOW_RAM_BYTES);
    localparam logic [`NUM_WREGS-1:0][7:0] WR_ADDR = {
        `ADDR_BASE_POINTER, `ADDR_STACK_POINTER, `ADDR_INDEX_POINTER,
        `ADDR_STATUS_WORD, `ADDR_TIMER_SERIAL_CTRL, `ADDR_RELOAD_HIGH,
        `ADDR_RELOAD_LOW, `ADDR_TIMER_HIGH, `ADDR_TIMER_LOW,
        `ADDR_SERIAL_SHIFT, `ADDR_OUTPUT_ONLY_DATA, `ADDR_PORT_G_CONFIG,
        `ADDR_PORT_G_DATA, `ADDR_PORT_L_CONFIG, `ADDR_PORT_L_DATA
    };
    localparam logic [`NUM_PIN_PORTS-1:0][7:0] PIN_ADDR = {
        `ADDR_INPUT_ONLY_PINS, `ADDR_PORT_G_PINS, `ADDR_PORT_L_PINS
    };
    localparam logic [`PC_WIDTH-1:0] PC_INIT = `PC_RESET;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [`NUM_PIN_PORTS-1:0][7:0] pins_raw;
    logic [`NUM_PIN_PORTS-1:0][7:0] pins_meta_q;
    logic [`NUM_PIN_PORTS-1:0][7:0] pins_sync_q;

    assign pins_raw[`PIN_PORT_L] = port_l_pins;
    assign pins_raw[`PIN_PORT_G] = port_g_pins;
    assign pins_raw[`PIN_INPUT_ONLY] = input_only_pins;

    for (genvar p = 0; p < `NUM_PIN_PORTS; p++) begin : g_sync
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                pins_meta_q[p] <= `REG_RESET;
                pins_sync_q[p] <= `REG_RESET;
            end else begin
                pins_meta_q[p] <= pins_raw[p];
                pins_sync_q[p] <= pins_meta_q[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    wire [7:0] a = req.addr;
    wire [`NUM_WREGS-1:0] sel_wreg;
    wire [`NUM_PIN_PORTS-1:0] sel_pins;
    wire sel_low_ram = {1'b0, a} < LOW_RAM_LIMIT;
    wire sel_pointer = sel_wreg[`IDX_INDEX_POINTER] | sel_wreg[`IDX_INDEX_POINTER + 1]
        | sel_wreg[`IDX_BASE_POINTER];
    wire sel_reg_ram = (a[7:4] == `REG_PAGE) & ~sel_pointer;
    wire sel_ram = sel_low_ram | sel_reg_ram;

    for (genvar i = 0; i < `NUM_WREGS; i++) begin : g_wsel
        assign sel_wreg[i] = (a == WR_ADDR[i]);
    end

    for (genvar p = 0; p < `NUM_PIN_PORTS; p++) begin : g_psel
        assign sel_pins[p] = (a == PIN_ADDR[p]);
    end

    wire sel_unused = ~(sel_ram | (|sel_wreg) | (|sel_pins));

    ////////////////////////////////////////////////////////////////////////////
    // storage: ram bytes and register-page bytes share one array

    wire [STORE_AW-1:0] store_index = sel_low_ram ? STORE_AW'(a)
        : REG_PAGE_BASE + STORE_AW'(a[3:0]);
    wire ram_wr = req.wr & sel_ram;
    data_space_pkg::byte_t ram_rdata;

    data_byte_store #(
        .DEPTH(STORE_DEPTH),
        .AW(STORE_AW)
    ) u_store (
        .ref_clk(ref_clk),
        .wr_en(ram_wr),
        .wr_index(store_index),
        .wr_data(req.wdata),
        .rd_index(store_index),
        .rd_data(ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // writable registers

    logic [`NUM_WREGS-1:0][7:0] wreg_q;

    // only a matching register takes a write
    for (genvar i = 0; i < `NUM_WREGS; i++) begin : g_wreg
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                wreg_q[i] <= `REG_RESET;
            end else if (req.wr && sel_wreg[i]) begin
                wreg_q[i] <= req.wdata;
            end
        end
    end

    // pointers are writable registers, not bytes of the shared ram array
    assign regs_q = wreg_q;

    ////////////////////////////////////////////////////////////////////////////
    // read multiplexer

    // one-hot and-or select, no clock in the path
    logic [`NUM_WREGS:0][7:0] wreg_part;
    logic [`NUM_PIN_PORTS:0][7:0] pins_part;
    assign wreg_part[0] = {8{sel_ram}} & ram_rdata;
    assign pins_part[0] = {8{sel_unused}} & `UNUSED_READ;

    for (genvar i = 0; i < `NUM_WREGS; i++) begin : g_wrd
        assign wreg_part[i + 1] = wreg_part[i] | ({8{sel_wreg[i]}} & wreg_q[i]);
    end

    for (genvar p = 0; p < `NUM_PIN_PORTS; p++) begin : g_prd
        assign pins_part[p + 1] = pins_part[p] | ({8{sel_pins[p]}} & pins_sync_q[p]);
    end

    assign rd_data = wreg_part[`NUM_WREGS] | pins_part[`NUM_PIN_PORTS];

    ////////////////////////////////////////////////////////////////////////////
    // operand resolution

    data_space_pkg::byte_t base_ptr;
    data_space_pkg::byte_t index_ptr;
    assign base_ptr = wreg_q[`IDX_BASE_POINTER];
    assign index_ptr = wreg_q[`IDX_INDEX_POINTER];

    wire is_base = operand.form == data_space_pkg::FORM_BASE_IND;
    wire is_index = operand.form == data_space_pkg::FORM_INDEX_IND;
    wire is_reg = operand.form == data_space_pkg::FORM_REGISTER;
    wire [7:0] reg_addr = {`REG_PAGE, operand.field[3:0]};
    wire [7:0] ptr_addr = is_base ? base_ptr : index_ptr;
    wire [7:0] dir_addr = is_reg ? reg_addr : operand.field;

    assign operand_addr = (is_base | is_index) ? ptr_addr : dir_addr;
    assign operand_is_imm = operand.form == data_space_pkg::FORM_IMMEDIATE;
    assign operand_bit_mask = 8'h01 << operand.bit_num;

    ////////////////////////////////////////////////////////////////////////////
    // accumulator and program counter, outside the data space

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            acc_q <= `REG_RESET;
        end else if (acc_load) begin
            acc_q <= acc_value;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            program_counter_q[`PC_HIGH_LSB-1:0] <= PC_INIT[`PC_HIGH_LSB-1:0];
        end else if (pc_load) begin
            program_counter_q[`PC_HIGH_LSB-1:0] <= pc_value[`PC_HIGH_LSB-1:0];
        end
    end

    // high part loads on its own or with the whole counter
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            program_counter_q[`PC_WIDTH-1:`PC_HIGH_LSB] <= PC_INIT[`PC_WIDTH-1:`PC_HIGH_LSB];
        end else if (pc_load) begin
            program_counter_q[`PC_WIDTH-1:`PC_HIGH_LSB] <= pc_value[`PC_WIDTH-1:`PC_HIGH_LSB];
        end else if (counter_high_load) begin
            program_counter_q[`PC_WIDTH-1:`PC_HIGH_LSB] <= counter_high_value;
        end
    end

    assign counter_high_part_q = program_counter_q[`PC_WIDTH-1:`PC_HIGH_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_ram_write;
        req.wr && !req.rd && sel_low_ram;
    endsequence

    sequence s_same_read;
        req.rd && !req.wr && a == $past(a);
    endsequence

    AST_ONE_TARGET: assert property (
        $onehot({sel_ram, sel_wreg, sel_pins, sel_unused}))
        else $error("address selects other than one target");

    AST_UNUSED_ONES: assert property (
        req.rd && {1'b0, a} >= LOW_RAM_LIMIT && a <= 8'h7f |-> rd_data == `UNUSED_READ)
        else $error("unused low space does not read all ones");

    AST_RAM_BACK: assert property (
        s_ram_write ##1 s_same_read |-> rd_data == $past(req.wdata))
        else $error("ram byte does not read back its write");

    AST_PIN_VIEW: assert property (
        req.rd && a == 8'hd7 |-> rd_data == $past(input_only_pins, 2))
        else $error("input-only pins not seen two clocks later");

    AST_IGNORED_WRITE: assert property (
        req.wr && (sel_unused || (|sel_pins)) |=> $stable(wreg_q))
        else $error("write to unused or read-only address changed a register");

    AST_TIMER_HIGH: assert property (
        req.wr && a == 8'heb |=> wreg_q[`IDX_TIMER_HIGH] == $past(req.wdata) ##1
        (wreg_q[`IDX_TIMER_HIGH] == $past(wreg_q[`IDX_TIMER_HIGH]) || $past(req.wr)))
        else $error("timer high byte not written at its address");

    AST_PTR_FETCH: assert property (
        is_base |-> operand_addr == base_ptr)
        else $error("base indirect operand not at base pointer");

    AST_INDEX_FETCH: assert property (
        req.wr && a == 8'hfc ##1 is_index |-> operand_addr == $past(req.wdata))
        else $error("index indirect operand not at new index pointer");

    AST_REG_RANGE: assert property (
        is_reg |-> operand_addr[7:4] == 4'hf && operand_addr[3:0] == operand.field[3:0])
        else $error("register operand outside its page");

    AST_PC_HIGH: assert property (
        counter_high_load && !pc_load |=> counter_high_part_q == $past(counter_high_value)
        && program_counter_q[7:0] == $past(program_counter_q[7:0]))
        else $error("high part load disturbed the low part");

    AST_EXPANSION_EMPTY: assert property (
        a >= 8'h80 && a <= 8'hbf |-> sel_unused && !ram_wr)
        else $error("erasable ram expansion space has a target");

    AST_IO_EXPANSION: assert property (
        a >= 8'hc0 && a <= 8'hcf |-> sel_unused && !ram_wr)
        else $error("io expansion space has a target");

    AST_PORT_RESERVED: assert property (
        (a == 8'hd3 || (a >= 8'hd8 && a <= 8'hdb)) |-> sel_unused)
        else $error("reserved port address has a target");

    AST_FUTURE_RESERVED: assert property (
        a >= 8'he0 && a <= 8'he8 |-> sel_unused)
        else $error("reserved function address has a target");

    AST_SHIFT_WRITE: assert property (
        req.wr && a == `ADDR_SERIAL_SHIFT |=> regs_q.serial_shift_data == $past(req.wdata))
        else $error("serial shift byte not written at its address");

    AST_CONTROL_WRITE: assert property (
        req.wr && a == `ADDR_TIMER_SERIAL_CTRL |=> regs_q.timer_serial_control == $past(req.wdata))
        else $error("control byte not written at its address");

    AST_STACK_WRITE: assert property (
        req.wr && a == `ADDR_STACK_POINTER |=> regs_q.stack_pointer == $past(req.wdata))
        else $error("stack pointer not written at its address");

    AST_PORT_L_WRITE: assert property (
        req.wr && a == `ADDR_PORT_L_DATA |=> regs_q.port_l_output_data == $past(req.wdata))
        else $error("first port data not written at its address");

    AST_BIT_ONEHOT: assert property (
        $onehot(operand_bit_mask) && operand_bit_mask[operand.bit_num])
        else $error("bit mask does not select exactly the numbered bit");

    AST_PC_LOAD: assert property (
        pc_load |=> program_counter_q == $past(pc_value))
        else $error("program counter did not take its load");

    AST_ACC_LOAD: assert property (
        acc_load |=> acc_q == $past(acc_value))
        else $error("accumulator did not take its load");

endmodule : data_space_address_decoder

// >>> design/data_space_cfg.svh
`ifndef DATA_SPACE_CFG_SVH
`define DATA_SPACE_CFG_SVH

// data space layout
`define LOW_RAM_DEFAULT_BYTES 48
`define LOW_SPACE_BYTES 128
`define REG_PAGE_BYTES 16
`define REG_PAGE 4'hf
`define UNUSED_READ 8'hff
`define REG_RESET 8'h00
`define PC_RESET 15'h0000

// writable register and read-only pin view addresses
`define ADDR_PORT_L_DATA 8'hd0
`define ADDR_PORT_L_CONFIG 8'hd1
`define ADDR_PORT_L_PINS 8'hd2
`define ADDR_PORT_G_DATA 8'hd4
`define ADDR_PORT_G_CONFIG 8'hd5
`define ADDR_PORT_G_PINS 8'hd6
`define ADDR_INPUT_ONLY_PINS 8'hd7
`define ADDR_OUTPUT_ONLY_DATA 8'hdc
`define ADDR_SERIAL_SHIFT 8'he9
`define ADDR_TIMER_LOW 8'hea
`define ADDR_TIMER_HIGH 8'heb
`define ADDR_RELOAD_LOW 8'hec
`define ADDR_RELOAD_HIGH 8'hed
`define ADDR_TIMER_SERIAL_CTRL 8'hee
`define ADDR_STATUS_WORD 8'hef
`define ADDR_INDEX_POINTER 8'hfc
`define ADDR_STACK_POINTER 8'hfd
`define ADDR_BASE_POINTER 8'hfe

// positions in the writable register array
`define NUM_WREGS 15
`define IDX_TIMER_HIGH 7
`define IDX_INDEX_POINTER 12
`define IDX_BASE_POINTER 14

// pin views
`define NUM_PIN_PORTS 3
`define PIN_PORT_L 0
`define PIN_PORT_G 1
`define PIN_INPUT_ONLY 2

// program counter split
`define PC_WIDTH 15
`define PC_HIGH_LSB 8

`endif

// >>> design/data_space_pkg.sv
package data_space_pkg;

    typedef logic [7:0] byte_t;

    // one access from the core datapath; rd and wr together is an exchange
    typedef struct packed {
        logic rd;
        logic wr;
        byte_t addr;
        byte_t wdata;
    } data_req_t;

    typedef enum logic [2:0] {
        FORM_DIRECT,
        FORM_BASE_IND,
        FORM_INDEX_IND,
        FORM_IMMEDIATE,
        FORM_REGISTER
    } operand_form_t;

    typedef struct packed {
        operand_form_t form;
        byte_t field;
        logic [2:0] bit_num;
    } operand_req_t;

    // field order mirrors the register array, highest index first
    typedef struct packed {
        byte_t base_pointer;
        byte_t stack_pointer;
        byte_t index_pointer;
        byte_t processor_status_word;
        byte_t timer_serial_control;
        byte_t timer_reload_high;
        byte_t timer_reload_low;
        byte_t timer_count_high;
        byte_t timer_count_low;
        byte_t serial_shift_data;
        byte_t output_only_port_data;
        byte_t port_g_pin_config;
        byte_t port_g_output_data;
        byte_t port_l_pin_config;
        byte_t port_l_output_data;
    } periph_regs_t;

endpackage : data_space_pkg

// >>> design/data_byte_store.sv
`timescale 1ns/1ns
module data_byte_store #(
    parameter int DEPTH = 64,
    parameter int AW = 7
) (
    // clock
    input wire logic ref_clk,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_index,
    input wire logic [7:0] wr_data,
    // read side
    input wire logic [AW-1:0] rd_index,
    output logic [7:0] rd_data
);

    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
        $error("data_byte_store: DEPTH does not fit AW");
    end

    // contents are undefined after reset, as plain RAM would be
    logic [7:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_index] <= wr_data;
        end
    end

    assign rd_data = mem[rd_index];

endmodule : data_byte_store

// >>> testbench/core_model.sv
`timescale 1ns/1ns
module core_model (
    // clock
    input wire logic ref_clk,
    // data access toward the decoder
    output data_space_pkg::data_req_t req,
    input wire data_space_pkg::byte_t rd_data
);
    initial begin
        req = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one access: request held from a falling edge through the taking edge
    task automatic access(input logic rd, input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(negedge ref_clk);
        req.rd = rd;
        req.wr = wr;
        req.addr = a;
        req.wdata = d;
        @(posedge ref_clk);
        // sampled before the edge's register updates land
        q = rd_data;
        @(negedge ref_clk);
        req.rd = 1'b0;
        req.wr = 1'b0;
        // idle bus does not keep the last address or data
        req.addr = ~a;
        req.wdata = ~d;
    endtask : access

    // a write and a read of the same byte on two back-to-back edges
    task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge ref_clk);
        req.rd = 1'b0;
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge ref_clk);
        req.rd = 1'b1;
        req.wr = 1'b0;
        @(posedge ref_clk);
        q = rd_data;
        @(negedge ref_clk);
        req.rd = 1'b0;
        req.addr = ~a;
        req.wdata = ~d;
    endtask : write_read
endmodule : core_model

// >>> testbench/data_space_address_decoder_bench.sv
`timescale 1ns/1ns
module data_space_address_decoder_bench;
    logic ref_clk;
    logic nrst;
    data_space_pkg::data_req_t req;
    data_space_pkg::byte_t rd_data;
    data_space_pkg::operand_req_t operand;
    data_space_pkg::byte_t operand_addr;
    logic operand_is_imm;
    data_space_pkg::byte_t operand_bit_mask;
    logic acc_load;
    data_space_pkg::byte_t acc_value;
    logic pc_load;
    logic [14:0] pc_value;
    logic counter_high_load;
    logic [6:0] counter_high_value;
    data_space_pkg::byte_t acc_q;
    logic [14:0] program_counter_q;
    logic [6:0] counter_high_part_q;
    data_space_pkg::byte_t port_l_pins;
    data_space_pkg::byte_t port_g_pins;
    data_space_pkg::byte_t input_only_pins;
    data_space_pkg::periph_regs_t regs_q;
    int err_count;
    int n_tests;
    // writable registers in regs_q order, lowest field first
    logic [7:0] wr_addrs [0:14] = '{8'hd0, 8'hd1, 8'hd4, 8'hd5, 8'hdc, 8'he9, 8'hea, 8'heb,
                                   8'hec, 8'hed, 8'hee, 8'hef, 8'hfc, 8'hfd, 8'hfe};
    logic [7:0] unused_addrs [0:13] = '{8'h30, 8'h7f, 8'h80, 8'hbf, 8'hc0, 8'hcf, 8'hd3,
                                       8'hd8, 8'hdb, 8'hdd, 8'hdf, 8'he0, 8'he7, 8'he8};

    data_space_address_decoder dut (
        .ref_clk(ref_clk), .nrst(nrst), .req(req), .rd_data(rd_data), .operand(operand),
        .operand_addr(operand_addr), .operand_is_imm(operand_is_imm),
        .operand_bit_mask(operand_bit_mask), .acc_load(acc_load), .acc_value(acc_value),
        .pc_load(pc_load), .pc_value(pc_value), .counter_high_load(counter_high_load),
        .counter_high_value(counter_high_value), .acc_q(acc_q),
        .program_counter_q(program_counter_q), .counter_high_part_q(counter_high_part_q),
        .port_l_pins(port_l_pins), .port_g_pins(port_g_pins),
        .input_only_pins(input_only_pins), .regs_q(regs_q)
    );
    core_model core (.ref_clk(ref_clk), .req(req), .rd_data(rd_data));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        core.access(1'b0, 1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        core.access(1'b1, 1'b0, a, 8'h00, q);
        check(q, exp);
    endtask : rd

    task automatic op(input data_space_pkg::operand_form_t f, input logic [7:0] fld,
                      input logic [7:0] exp);
        @(negedge ref_clk);
        operand.form = f;
        operand.field = fld;
        #1 check(operand_addr, exp);
        check(operand_is_imm, f == data_space_pkg::FORM_IMMEDIATE);
    endtask : op

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        for (int i = 0; i < 15; i++) begin
            wr(wr_addrs[i], 8'h30 + 8'(i));
        end
        for (int i = 0; i < 15; i++) begin
            rd(wr_addrs[i], 8'h30 + 8'(i));
            check(regs_q[8*i +: 8], 8'h30 + 8'(i));
        end
        $display("test regs done");
    endtask : t_regs

    task automatic t_ram;
        wr(8'h00, 8'h11);
        wr(8'h2f, 8'h22);
        wr(8'hf0, 8'h33);
        wr(8'hff, 8'h44);
        rd(8'h00, 8'h11);
        rd(8'h2f, 8'h22);
        rd(8'hf0, 8'h33);
        rd(8'hff, 8'h44);
        $display("test ram done");
    endtask : t_ram

    task automatic t_unused;
        data_space_pkg::periph_regs_t snap;
        snap = regs_q;
        for (int i = 0; i < 14; i++) begin
            wr(unused_addrs[i], 8'h5a);
        end
        wr(8'hd2, 8'h5a);
        wr(8'hd6, 8'h5a);
        wr(8'hd7, 8'h5a);
        for (int i = 0; i < 14; i++) begin
            rd(unused_addrs[i], 8'hff);
        end
        check(16'(regs_q == snap), 16'h0001);
        rd(8'h2f, 8'h22);
        $display("test unused done");
    endtask : t_unused

    task automatic t_pins;
        @(negedge ref_clk);
        port_l_pins = 8'ha1;
        port_g_pins = 8'hb2;
        input_only_pins = 8'hc3;
        repeat (3) @(posedge ref_clk);
        rd(8'hd2, 8'ha1);
        rd(8'hd6, 8'hb2);
        rd(8'hd7, 8'hc3);
        $display("test pins done");
    endtask : t_pins

    task automatic t_exchange;
        logic [7:0] q;
        core.access(1'b1, 1'b1, 8'hd0, 8'hc7, q);
        check(q, 8'h30);
        rd(8'hd0, 8'hc7);
        check(regs_q.port_l_output_data, 8'hc7);
        $display("test exchange done");
    endtask : t_exchange

    task automatic t_operand;
        op(data_space_pkg::FORM_BASE_IND, 8'h12, 8'h3e);
        op(data_space_pkg::FORM_INDEX_IND, 8'h12, 8'h3c);
        op(data_space_pkg::FORM_REGISTER, 8'h35, 8'hf5);
        op(data_space_pkg::FORM_DIRECT, 8'h47, 8'h47);
        op(data_space_pkg::FORM_IMMEDIATE, 8'h9c, 8'h9c);
        for (int b = 0; b < 8; b++) begin
            @(negedge ref_clk);
            operand.bit_num = 3'(b);
            #1 check(operand_bit_mask, 8'h01 << b);
        end
        $display("test operand done");
    endtask : t_operand

    task automatic t_acc_pc;
        @(negedge ref_clk);
        acc_load = 1'b1;
        acc_value = 8'h96;
        pc_load = 1'b1;
        pc_value = 15'h5abc;
        @(negedge ref_clk);
        acc_load = 1'b0;
        pc_load = 1'b0;
        counter_high_load = 1'b1;
        counter_high_value = 7'h13;
        check(acc_q, 8'h96);
        check(program_counter_q, 15'h5abc);
        check(counter_high_part_q, 7'h5a);
        @(negedge ref_clk);
        counter_high_load = 1'b0;
        check(program_counter_q, 15'h13bc);
        check(counter_high_part_q, 7'h13);
        $display("test acc pc done");
    endtask : t_acc_pc

    task automatic t_back_to_back;
        logic [7:0] q;
        core.write_read(8'h10, 8'h6d, q);
        check(q, 8'h6d);
        @(negedge ref_clk);
        operand.form = data_space_pkg::FORM_INDEX_IND;
        core.write_read(8'hfc, 8'h21, q);
        check(q, 8'h21);
        check(operand_addr, 8'h21);
        core.write_read(8'hd7, 8'h5a, q);
        check(q, 8'hc3);
        $display("test back to back done");
    endtask : t_back_to_back

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        // far longer than the few hundred cycles the tests take
        repeat (20000) @(posedge ref_clk);
        err_count++;
        $display("watchdog expired");
        finish_test();
    end

    initial begin
        err_count = 0;
        n_tests = 0;
        nrst = 1'b0;
        operand = '0;
        {acc_load, pc_load, counter_high_load} = 3'b000;
        acc_value = 8'h00;
        pc_value = 15'h0000;
        counter_high_value = 7'h00;
        {port_l_pins, port_g_pins, input_only_pins} = 24'h000000;
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        for (int i = 0; i < 15; i++) begin
            check(regs_q[8*i +: 8], 8'h00);
        end
        check(acc_q, 8'h00);
        check(program_counter_q, 15'h0000);
        t_regs();
        t_ram();
        t_unused();
        t_pins();
        t_exchange();
        t_operand();
        t_acc_pc();
        t_back_to_back();
        finish_test();
    end
endmodule : data_space_address_decoder_bench
